/* File: src/spl_pkg.sv */
// Purpose: Shared constants and types of the serial program loader.
// Assumes: System clock at CLK_HZ; all opcodes are the first or second instruction byte.
// Notes: Wait counts above 4096 cycles are passed on as top-level parameter defaults.
`default_nettype none

package spl_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int FLASH_WAIT_US = 4500;
    localparam int EEPROM_WAIT_US = 9000;
    localparam int ERASE_WAIT_US = 9000;
    localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * (CLK_HZ / 1_000_000);
    localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * (CLK_HZ / 1_000_000);
    localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * (CLK_HZ / 1_000_000);
    localparam int WAIT_W = 17;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int PAGE_AW = 7;
    localparam int EE_PAGE_AW = 2;
    localparam int IDX_W = 17;
    localparam int SYNC_N = 3;
    // ------------------------------------------------------------------
    // Values after reset and after erase
    // ------------------------------------------------------------------
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] FUSE_RST = 8'hff;
    localparam logic [7:0] LOCK_RST = 8'hff;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_PROG = 8'hac;
    localparam logic [7:0] OP2_ENABLE = 8'h53;
    localparam logic [7:0] OP2_ERASE = 8'h80;
    localparam logic [7:0] OP2_WR_LOCK = 8'he0;
    localparam logic [7:0] OP2_WR_FLO = 8'ha0;
    localparam logic [7:0] OP2_WR_FHI = 8'ha8;
    localparam logic [7:0] OP2_WR_FEXT = 8'ha4;
    localparam logic [7:0] OP2_HIGH_SEL = 8'h08;
    localparam logic [7:0] OP_POLL = 8'hf0;
    localparam logic [7:0] OP_LD_EXT = 8'h4d;
    localparam logic [7:0] OP_LD_HI = 8'h48;
    localparam logic [7:0] OP_LD_LO = 8'h40;
    localparam logic [7:0] OP_LD_EEPG = 8'hc1;
    localparam logic [7:0] OP_RD_HI = 8'h28;
    localparam logic [7:0] OP_RD_LO = 8'h20;
    localparam logic [7:0] OP_RD_EE = 8'ha0;
    localparam logic [7:0] OP_RD_LOCK = 8'h58;
    localparam logic [7:0] OP_RD_FUSE = 8'h50;
    localparam logic [7:0] OP_RD_SIG = 8'h30;
    localparam logic [7:0] OP_RD_CAL = 8'h38;
    localparam logic [7:0] OP_WR_PAGE = 8'h4c;
    localparam logic [7:0] OP_WR_EE = 8'hc0;
    localparam logic [7:0] OP_WR_EEPG = 8'hc2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_COPY,
        ST_EECOPY,
        ST_ERASE,
        ST_WAIT
    } spl_state_t;
endpackage

`default_nettype wire

/* File: src/spl_link.sv */
// Purpose: Serial-clock side of the loader: byte framing, echo and answer shifting.
// Assumes: Link reset is high whenever the programmer releases the device reset pin.
// Notes: The answer byte is taken on the falling edge that opens byte four.
`default_nettype none

module spl_link (
    input wire logic sck_i,          // Serial clock from the programmer
    input wire logic link_rst_i,     // Asynchronous link reset, high active
    input wire logic mosi_i,         // Serial data in
    input wire logic [7:0] resp_i,   // Answer byte, stable during byte four
    output logic [7:0] b1_o,         // Instruction byte one
    output logic [7:0] b2_o,         // Instruction byte two
    output logic [7:0] b3_o,         // Instruction byte three
    output logic [7:0] b4_o,         // Instruction byte four
    output logic hdr_tgl_o,          // Toggles once bytes one to three are in
    output logic cmd_tgl_o,          // Toggles once all four bytes are in
    output logic miso_o              // Serial data out
);
    import spl_pkg::*;

    logic [7:0] sh_reg, sh_next;
    logic [2:0] bit_reg, bit_next;
    logic [1:0] byte_reg, byte_next;
    logic [7:0] b1_reg, b1_next, b2_reg, b2_next, b3_reg, b3_next, b4_reg, b4_next;
    logic [7:0] prev_reg, prev_next;
    logic hdr_reg, hdr_next, cmd_reg, cmd_next;
    logic [7:0] out_reg, out_next;
    logic miso_reg, miso_next;
    logic [7:0] src;

    // ------------------------------------------------------------------
    // Rising edge: capture
    // ------------------------------------------------------------------
    always_comb begin
        sh_next = {sh_reg[6:0], mosi_i};
        bit_next = bit_reg + 3'd1;
        byte_next = byte_reg;
        b1_next = b1_reg;
        b2_next = b2_reg;
        b3_next = b3_reg;
        b4_next = b4_reg;
        prev_next = prev_reg;
        hdr_next = hdr_reg;
        cmd_next = cmd_reg;
        if (bit_reg == 3'd7) begin
            byte_next = byte_reg + 2'd1;
            prev_next = sh_next;
            unique case (byte_reg)
                2'd0: b1_next = sh_next;
                2'd1: b2_next = sh_next;
                2'd2: begin
                    b3_next = sh_next;
                    hdr_next = ~hdr_reg;
                end
                2'd3: begin
                    b4_next = sh_next;
                    cmd_next = ~cmd_reg;
                end
            endcase
        end
    end

    always_ff @(posedge sck_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            sh_reg <= BYTE_RST;
            bit_reg <= 3'd0;
            byte_reg <= 2'd0;
            b1_reg <= BYTE_RST;
            b2_reg <= BYTE_RST;
            b3_reg <= BYTE_RST;
            b4_reg <= BYTE_RST;
            prev_reg <= BYTE_RST;
            hdr_reg <= 1'b0;
            cmd_reg <= 1'b0;
        end else begin
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            b1_reg <= b1_next;
            b2_reg <= b2_next;
            b3_reg <= b3_next;
            b4_reg <= b4_next;
            prev_reg <= prev_next;
            hdr_reg <= hdr_next;
            cmd_reg <= cmd_next;
        end
    end

    // ------------------------------------------------------------------
    // Falling edge: shift out, echo of the previous byte or the answer
    // ------------------------------------------------------------------
    always_comb begin
        src = (byte_reg == 2'd3) ? resp_i : prev_reg;
        out_next = {out_reg[6:0], 1'b0};
        miso_next = out_reg[7];
        if (bit_reg == 3'd0) begin
            out_next = {src[6:0], 1'b0};
            miso_next = src[7];
        end
    end

    always_ff @(negedge sck_i or posedge link_rst_i) begin
        if (link_rst_i) begin
            out_reg <= BYTE_RST;
            miso_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            miso_reg <= miso_next;
        end
    end

    assign b1_o = b1_reg;
    assign b2_o = b2_reg;
    assign b3_o = b3_reg;
    assign b4_o = b4_reg;
    assign hdr_tgl_o = hdr_reg;
    assign cmd_tgl_o = cmd_reg;
    assign miso_o = miso_reg;
endmodule

`default_nettype wire

/* File: src/spl_loader.sv */
// Purpose: Serial in-system programming port: decodes four-byte instructions into
//          flash, EEPROM, fuse and lock operations.
// Assumes: Memories are arrays of this module; contents are undefined until erased.
// Notes: Link logic runs on the serial clock; events cross by toggle synchronisers.
`default_nettype none

module spl_loader #(
    parameter int FLASH_AW = 15,
    parameter int EE_AW = 11,
    parameter int FLASH_WAIT = spl_pkg::FLASH_WAIT_CYC,
    parameter int EEPROM_WAIT = spl_pkg::EEPROM_WAIT_CYC,
    parameter int ERASE_WAIT = spl_pkg::ERASE_WAIT_CYC,
    parameter logic [7:0] SIG0 = 8'h5a,  // Arbitrary identity value
    parameter logic [7:0] SIG1 = 8'h3c,  // Arbitrary identity value
    parameter logic [7:0] SIG2 = 8'h01,  // Arbitrary identity value
    parameter logic [7:0] CAL_VALUE = 8'h80
) (
    input wire logic clk_sys_i,      // System clock
    input wire logic sys_rst_i,      // Synchronous reset, high active
    input wire logic sck_i,          // Serial clock from the programmer
    input wire logic mosi_i,         // Serial data in
    input wire logic prog_rst_n_i,   // Device reset pin, low selects programming
    output logic miso_o,             // Serial data out
    output logic miso_oe_o,          // Drive enable for serial data out
    output logic prog_enabled_o,     // Programming enable accepted
    output logic pending_flag_o      // Operation in progress
);
    import spl_pkg::*;

    localparam int FLASH_WORDS = 1 << FLASH_AW;
    localparam int EE_BYTES = 1 << EE_AW;
    localparam int PAGE_WORDS = 1 << PAGE_AW;
    localparam int EE_PAGE = 1 << EE_PAGE_AW;
    localparam int ERASE_LEN = (FLASH_WORDS > EE_BYTES) ? FLASH_WORDS : EE_BYTES;

    logic [15:0] flash_mem [FLASH_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [7:0] pbuf_lo [PAGE_WORDS];
    logic [7:0] pbuf_hi [PAGE_WORDS];
    logic [7:0] ee_pbuf [EE_PAGE];

    logic [7:0] b1, b2, b3, b4;
    logic hdr_tgl, cmd_tgl, link_miso;
    logic [SYNC_N-1:0] s1_reg, s2_reg, s3_reg, flt_reg, flt_d_reg, flt_next;
    logic sel, hdr_ev, cmd_ev;

    spl_state_t state_reg, state_next;
    logic [IDX_W-1:0] idx_reg, idx_next;
    logic [WAIT_W-1:0] cnt_reg, cnt_next;
    logic enabled_reg, enabled_next, sel_reg, sel_next;
    logic [7:0] ext_reg, ext_next, resp_reg, resp_next;
    logic [7:0] flo_reg, flo_next, fhi_reg, fhi_next, fext_reg, fext_next;
    logic [7:0] lock_reg, lock_next;
    logic [FLASH_AW-1:0] page_reg, page_next, rd_fa;
    logic [EE_AW-1:0] eebase_reg, eebase_next, rd_ea;

    logic fl_we, ee_we, pl_we, ph_we, eb_we;
    logic [FLASH_AW-1:0] fl_wa;
    logic [15:0] fl_wd;
    logic [EE_AW-1:0] ee_wa;
    logic [7:0] ee_wd;
    logic busy;

    // ------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------
    function automatic logic [FLASH_AW-1:0] fl_addr(input logic [7:0] e, input logic [7:0] m,
                                                    input logic [7:0] l);
        logic [23:0] w;
        w = {e, m, l};
        return w[FLASH_AW-1:0];
    endfunction

    function automatic logic [EE_AW-1:0] ee_addr(input logic [7:0] m, input logic [7:0] l);
        logic [15:0] w;
        w = {m, l};
        return w[EE_AW-1:0];
    endfunction

    // ------------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------------
    spl_link u_link (
        .sck_i(sck_i),
        .link_rst_i(prog_rst_n_i),
        .mosi_i(mosi_i),
        .resp_i(resp_reg),
        .b1_o(b1),
        .b2_o(b2),
        .b3_o(b3),
        .b4_o(b4),
        .hdr_tgl_o(hdr_tgl),
        .cmd_tgl_o(cmd_tgl),
        .miso_o(link_miso)
    );

    // ------------------------------------------------------------------
    // Crossings: three stages, change accepted when stages two and three agree
    // ------------------------------------------------------------------
    logic [SYNC_N-1:0] sync_in;
    assign sync_in = {prog_rst_n_i, hdr_tgl, cmd_tgl};

    genvar g;
    generate
        for (g = 0; g < SYNC_N; g++) begin : g_sync
            always_comb begin
                flt_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : flt_reg[g];
            end
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i) begin
                    s1_reg[g] <= (g == 2) ? 1'b1 : 1'b0;
                    s2_reg[g] <= (g == 2) ? 1'b1 : 1'b0;
                    s3_reg[g] <= (g == 2) ? 1'b1 : 1'b0;
                    flt_reg[g] <= (g == 2) ? 1'b1 : 1'b0;
                    flt_d_reg[g] <= (g == 2) ? 1'b1 : 1'b0;
                end else begin
                    s1_reg[g] <= sync_in[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    flt_reg[g] <= flt_next[g];
                    flt_d_reg[g] <= flt_reg[g];
                end
            end
        end
    endgenerate

    assign sel = ~flt_reg[2];
    assign hdr_ev = flt_reg[1] ^ flt_d_reg[1];
    assign cmd_ev = flt_reg[0] ^ flt_d_reg[0];
    assign busy = (state_reg != ST_IDLE);
    assign rd_fa = fl_addr(ext_reg, b2, b3);
    assign rd_ea = ee_addr(b2, b3);

    // ------------------------------------------------------------------
    // Instruction decode and memory sequencing
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        cnt_next = cnt_reg;
        enabled_next = enabled_reg;
        sel_next = sel;
        ext_next = ext_reg;
        resp_next = resp_reg;
        flo_next = flo_reg;
        fhi_next = fhi_reg;
        fext_next = fext_reg;
        lock_next = lock_reg;
        page_next = page_reg;
        eebase_next = eebase_reg;
        fl_we = 1'b0;
        fl_wa = idx_reg[FLASH_AW-1:0];
        fl_wd = {ERASED_BYTE, ERASED_BYTE};
        ee_we = 1'b0;
        ee_wa = idx_reg[EE_AW-1:0];
        ee_wd = ERASED_BYTE;
        pl_we = 1'b0;
        ph_we = 1'b0;
        eb_we = 1'b0;

        unique case (state_reg)
            ST_IDLE: begin
            end
            ST_COPY: begin
                fl_we = 1'b1;
                fl_wa = {page_reg[FLASH_AW-1:PAGE_AW], idx_reg[PAGE_AW-1:0]};
                fl_wd = {pbuf_hi[idx_reg[PAGE_AW-1:0]], pbuf_lo[idx_reg[PAGE_AW-1:0]]};
                idx_next = idx_reg + 1'b1;
                if (idx_reg == IDX_W'(PAGE_WORDS - 1)) begin
                    state_next = ST_WAIT;
                    cnt_next = WAIT_W'(FLASH_WAIT);
                end
            end
            ST_EECOPY: begin
                ee_we = 1'b1;
                ee_wa = {eebase_reg[EE_AW-1:EE_PAGE_AW], idx_reg[EE_PAGE_AW-1:0]};
                ee_wd = ee_pbuf[idx_reg[EE_PAGE_AW-1:0]];
                idx_next = idx_reg + 1'b1;
                if (idx_reg == IDX_W'(EE_PAGE - 1)) begin
                    state_next = ST_WAIT;
                    cnt_next = WAIT_W'(EEPROM_WAIT);
                end
            end
            ST_ERASE: begin
                fl_we = (idx_reg < IDX_W'(FLASH_WORDS));
                ee_we = (idx_reg < IDX_W'(EE_BYTES));
                idx_next = idx_reg + 1'b1;
                if (idx_reg == IDX_W'(ERASE_LEN - 1)) begin
                    state_next = ST_WAIT;
                    cnt_next = WAIT_W'(ERASE_WAIT);
                end
            end
            ST_WAIT: begin
                cnt_next = cnt_reg - 1'b1;
                if (cnt_reg <= WAIT_W'(1)) begin
                    state_next = ST_IDLE;
                end
            end
        endcase

        // Answer byte, ready before byte four is shifted out
        if (hdr_ev) begin
            resp_next = BYTE_RST;
            if (b1 == OP_POLL) begin
                resp_next = {7'h00, busy};
            end else if (enabled_reg) begin
                unique case (b1)
                    OP_RD_HI: resp_next = flash_mem[rd_fa][15:8];
                    OP_RD_LO: resp_next = flash_mem[rd_fa][7:0];
                    OP_RD_EE: resp_next = ee_mem[rd_ea];
                    OP_RD_LOCK: resp_next = (b2 == OP2_HIGH_SEL) ? fhi_reg : lock_reg;
                    OP_RD_FUSE: resp_next = (b2 == OP2_HIGH_SEL) ? fext_reg : flo_reg;
                    OP_RD_SIG: begin
                        unique case (b3[1:0])
                            2'd0: resp_next = SIG0;
                            2'd1: resp_next = SIG1;
                            2'd2: resp_next = SIG2;
                            2'd3: resp_next = BYTE_RST;
                        endcase
                    end
                    OP_RD_CAL: resp_next = CAL_VALUE;
                    default: resp_next = BYTE_RST;
                endcase
            end
        end

        // Complete instruction; all but enable are ignored while an operation runs
        if (cmd_ev && sel) begin
            if (b1 == OP_PROG && b2 == OP2_ENABLE) begin
                enabled_next = 1'b1;
            end else if (enabled_reg && !busy) begin
                unique case (b1)
                    OP_PROG: begin
                        unique case (b2)
                            OP2_ERASE: begin
                                state_next = ST_ERASE;
                                idx_next = '0;
                                lock_next = LOCK_RST;
                            end
                            OP2_WR_LOCK: lock_next = b4;
                            OP2_WR_FLO: flo_next = b4;
                            OP2_WR_FHI: fhi_next = b4;
                            OP2_WR_FEXT: fext_next = b4;
                            default: begin
                            end
                        endcase
                    end
                    OP_LD_EXT: ext_next = b3;
                    OP_LD_LO: pl_we = 1'b1;
                    OP_LD_HI: ph_we = 1'b1;
                    OP_WR_PAGE: begin
                        page_next = fl_addr(ext_reg, b2, b3);
                        state_next = ST_COPY;
                        idx_next = '0;
                    end
                    OP_WR_EE: begin
                        ee_we = 1'b1;
                        ee_wa = ee_addr(b2, b3);
                        ee_wd = b4;
                        state_next = ST_WAIT;
                        cnt_next = WAIT_W'(EEPROM_WAIT);
                    end
                    OP_LD_EEPG: eb_we = 1'b1;
                    OP_WR_EEPG: begin
                        eebase_next = ee_addr(b2, b3);
                        state_next = ST_EECOPY;
                        idx_next = '0;
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (!sel) begin
            enabled_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            idx_reg <= '0;
            cnt_reg <= '0;
            enabled_reg <= 1'b0;
            sel_reg <= 1'b0;
            ext_reg <= BYTE_RST;
            resp_reg <= BYTE_RST;
            flo_reg <= FUSE_RST;
            fhi_reg <= FUSE_RST;
            fext_reg <= FUSE_RST;
            lock_reg <= LOCK_RST;
            page_reg <= '0;
            eebase_reg <= '0;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            cnt_reg <= cnt_next;
            enabled_reg <= enabled_next;
            sel_reg <= sel_next;
            ext_reg <= ext_next;
            resp_reg <= resp_next;
            flo_reg <= flo_next;
            fhi_reg <= fhi_next;
            fext_reg <= fext_next;
            lock_reg <= lock_next;
            page_reg <= page_next;
            eebase_reg <= eebase_next;
        end
    end

    // ------------------------------------------------------------------
    // Memory arrays
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (fl_we) begin
            flash_mem[fl_wa] <= fl_wd;
        end
        if (ee_we) begin
            ee_mem[ee_wa] <= ee_wd;
        end
        if (pl_we) begin
            pbuf_lo[b3[PAGE_AW-1:0]] <= b4;
        end
        if (ph_we) begin
            pbuf_hi[b3[PAGE_AW-1:0]] <= b4;
        end
        if (eb_we) begin
            ee_pbuf[b3[EE_PAGE_AW-1:0]] <= b4;
        end
    end

    assign miso_o = link_miso;
    assign miso_oe_o = sel_reg;
    assign prog_enabled_o = enabled_reg;
    assign pending_flag_o = (state_reg != ST_IDLE);
endmodule

`default_nettype wire

/* File: tb/spl_chk.sv */
// Purpose: Port checks of the serial program loader.
// Assumes: Bench uses short wait parameters.
// Notes: Bound to every spl_loader.
`default_nettype none
module spl_chk (
    input wire logic clk_sys_i,      // System clock
    input wire logic sys_rst_i,      // Reset
    input wire logic sck_i,          // Serial clock
    input wire logic mosi_i,         // Serial data in
    input wire logic prog_rst_n_i,   // Reset pin
    input wire logic miso_o,         // Serial data out
    input wire logic miso_oe_o,      // Data out enable
    input wire logic prog_enabled_o, // Enable state
    input wire logic pending_flag_o  // Busy state
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_pin_hi; prog_rst_n_i [*6]; endsequence
    sequence s_pin_lo; !prog_rst_n_i [*8]; endsequence
    property p_miso; sck_i && !prog_rst_n_i |-> $stable(miso_o); endproperty
    a_miso: assert property (p_miso) else $error("miso moved");
    property p_cause; $rose(pending_flag_o) |-> prog_enabled_o; endproperty
    a_cause: assert property (p_cause) else $error("busy unenabled");
    property p_pmin; $rose(pending_flag_o) |=> pending_flag_o [*8]; endproperty
    a_pmin: assert property (p_pmin) else $error("busy short");
    property p_pmax; $rose(pending_flag_o) |-> ##[1:1000] !pending_flag_o; endproperty
    a_pmax: assert property (p_pmax) else $error("busy stuck");
    property p_epin; $rose(prog_enabled_o) |-> !prog_rst_n_i; endproperty
    a_epin: assert property (p_epin) else $error("enable with pin high");
    property p_ehold; prog_enabled_o && !prog_rst_n_i |=> prog_enabled_o; endproperty
    a_ehold: assert property (p_ehold) else $error("enable lost");
    property p_off; s_pin_hi |-> !prog_enabled_o && !miso_oe_o; endproperty
    a_off: assert property (p_off) else $error("pin high active");
    property p_oe; s_pin_lo |-> miso_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("miso not driven");
endmodule
bind spl_loader spl_chk i_chk (.clk_sys_i, .sys_rst_i, .sck_i, .mosi_i, .prog_rst_n_i,
    .miso_o, .miso_oe_o, .prog_enabled_o, .pending_flag_o);
`default_nettype wire

/* File: tb/spl_prog.sv */
// Purpose: Programmer model driving the serial link.
// Assumes: Clock phases of about 1 us, well over two system clocks.
// Notes: Waits after the reset pin are shortened to 4 us.
`default_nettype none
module spl_prog (
    input wire logic lnk_clk_i, // Link timing clock
    input wire logic miso_i,    // Data from device
    output logic sck_o,         // Serial clock, low outside frames
    output logic mosi_o,        // Data to device
    output logic rst_n_o        // Reset pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        rst_n_o = 1'b0;
    end
    task automatic ph();
        repeat (67) @(posedge lnk_clk_i);
        #1;
    endtask
    task automatic pin(input logic v);
        rst_n_o = v;
        repeat (4) ph();
    endtask
    task automatic xb(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = b[i];
            ph();
            sck_o = 1'b1;
            r = {r[6:0], miso_i};
            ph();
            sck_o = 1'b0;
        end
        mosi_o = ~mosi_o;
    endtask
    task automatic instr(input logic [31:0] w, output logic [7:0] e, output logic [7:0] a);
        logic [7:0] d;
        xb(w[31:24], d);
        xb(w[23:16], d);
        xb(w[15:8], e);
        xb(w[7:0], a);
        ph();
        ph();
    endtask
endmodule
`default_nettype wire

/* File: tb/serial_program_loader_test.sv */
// Purpose: Self-checking bench of the serial program loader.
// Assumes: Programmer model drives the link.
// Notes: Memory sizes and waits shortened by parameters.
`default_nettype none
module serial_program_loader_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 1'b0;
    logic lnk = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sck, mosi, rst_n, miso, oe, en, pend;
    logic [7:0] e, a, p;
    int miscompares = 0;
    int n_tests = 0;
    logic [39:0] rows [26] = '{40'h4d00000000, 40'h4000051100, 40'h4800052200,
        40'h4c00003300, 40'h2000050011, 40'h2800050022, 40'h20008000ff, 40'ha0000300ff,
        40'hc000037700, 40'ha000030077, 40'hc000035500, 40'ha000030055, 40'hc100010900,
        40'hc200040000, 40'ha000050009, 40'h58000000ff, 40'hace000fc00, 40'h58000000fc,
        40'haca000e100, 40'h50000000e1, 40'haca800d200, 40'h58080000d2, 40'haca400f300,
        40'h50080000f3, 40'hac80000000, 40'h58000000ff};
    wire logic miso_w = oe ? miso : ~miso;
    always #50 clk_sys_i = ~clk_sys_i;
    initial #3.3 forever #7.5 lnk = ~lnk;
    spl_loader #(.FLASH_AW(9), .EE_AW(6), .FLASH_WAIT(20), .EEPROM_WAIT(30),
        .ERASE_WAIT(30)) i_spl_loader (.clk_sys_i, .sys_rst_i, .sck_i(sck), .mosi_i(mosi),
        .prog_rst_n_i(rst_n), .miso_o(miso), .miso_oe_o(oe), .prog_enabled_o(en),
        .pending_flag_o(pend));
    spl_prog i_spl_prog (.lnk_clk_i(lnk), .miso_i(miso_w), .sck_o(sck), .mosi_o(mosi),
        .rst_n_o(rst_n));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
        n_tests++;
        if (s !== x) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, x, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic run(input logic [31:0] w);
        i_spl_prog.instr(w, e, a);
        p = 8'h01;
        for (int k = 0; k < 20 && p[0] === 1'b1; k++) i_spl_prog.instr(32'hf0000000, e, p);
        chk("idle", p, 8'h00);
    endtask
    initial begin
        #8ms;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        chk("reset enable", {7'h0, en}, 8'h00);
        #1 sys_rst_i = 1'b0;
        i_spl_prog.pin(1'b1);
        i_spl_prog.pin(1'b0);
        run(32'hac800000);
        chk("early erase", {7'h0, pend}, 8'h00);
        run(32'h58000000);
        chk("early read", a, 8'h00);
        i_spl_prog.instr(32'hac530000, e, a);
        chk("echo", e, 8'h53);
        chk("enabled", {7'h0, en}, 8'h01);
        i_spl_prog.instr(32'hac800000, e, a);
        i_spl_prog.instr(32'hf0000000, e, p);
        chk("busy poll", p, 8'h01);
        run(32'hf0000000);
        foreach (rows[i]) begin
            run(rows[i][39:8]);
            chk("answer", a, rows[i][7:0]);
        end
        i_spl_prog.pin(1'b1);
        chk("pin drop", {7'h0, en}, 8'h00);
        i_spl_prog.pin(1'b0);
        i_spl_prog.instr(32'hac540000, e, a);
        chk("bad enable", {7'h0, en}, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
